// ==== hdl/fid_defs.vh ====
// Constants for the fourteen-bit instruction decode block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef FID_DEFS_VH
`define FID_DEFS_VH

// ****************************************
// Word and field layout
// ****************************************
`define FID_WORD_W        14
`define FID_OPC_HI        13
`define FID_OPC_LO        8
`define FID_DEST_BIT      7
`define FID_FILE_HI       6
`define FID_FILE_LO       0
`define FID_BIT_HI        9
`define FID_BIT_LO        7
`define FID_LIT8_HI       7
`define FID_LIT11_HI      10
`define FID_CLASS_HI      13
`define FID_CLASS_LO      12
`define FID_LONG_HI       13
`define FID_LONG_LO       11
`define FID_BIT_TEST_POS  11

// ****************************************
// Class codes and special encodings
// ****************************************
`define FID_CLASS_BYTE    2'h0
`define FID_CLASS_BITOP   2'h1
`define FID_CLASS_LIT     2'h2
`define FID_LONG_CODE     3'h4
`define FID_LONG_MASK     3'h6
`define FID_OPC_MISC      6'h00
`define FID_OPC_CLRACC    6'h01
`define FID_FILE_MAX      7'h7f
`define FID_DEST_ACC      1'h0
`define FID_DEST_FILE     1'h1

// ****************************************
// Timing
// ****************************************
`define FID_PHASES        4
`define FID_PH_Q1         2'h0
`define FID_PH_Q2         2'h1
`define FID_PH_Q3         2'h2
`define FID_PH_Q4         2'h3

`endif

// ==== hdl/fid_phase_gen.v ====
// Splits the oscillator clock into four phases per instruction cycle.
// Assumes mclk is the oscillator and rst_n is synchronous.
`timescale 1ns/10ps
`include "fid_defs.vh"

module fid_phase_gen (
	input  wire       mclk,
	input  wire       rst_n,
	output reg  [1:0] phase,
	output wire       last_phase
);

	// ****************************************
	// Phase counter
	// ****************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			phase <= `FID_PH_Q1;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign last_phase = (phase == `FID_PH_Q4);

endmodule

// ==== hdl/fid_field_split.v ====
// Splits a fourteen-bit instruction word into its class and operand fields.
// Pure combinational; the caller registers the results.
`timescale 1ns/10ps
`include "fid_defs.vh"

module fid_field_split (
	input  wire [13:0] word,
	output reg  [1:0]  iclass,
	output wire [5:0]  opcode,
	output wire        dest_sel,
	output reg  [6:0]  file_addr,
	output wire [2:0]  bit_sel,
	output reg  [10:0] literal,
	output reg         long_lit,
	output reg         names_file
);

	wire [1:0] top_bits;
	wire       is_misc;
	wire       is_clracc;

	assign top_bits  = word[`FID_CLASS_HI:`FID_CLASS_LO];
	assign opcode    = word[`FID_OPC_HI:`FID_OPC_LO];
	assign dest_sel  = word[`FID_DEST_BIT];
	assign bit_sel   = word[`FID_BIT_HI:`FID_BIT_LO];
	assign is_misc   = (opcode == `FID_OPC_MISC) && (dest_sel == `FID_DEST_ACC);
	assign is_clracc = (opcode == `FID_OPC_CLRACC) && (dest_sel == `FID_DEST_ACC);

	// ****************************************
	// Class and operand selection
	// ****************************************
	always @* begin
		iclass     = (top_bits == `FID_CLASS_BYTE)  ? `FID_CLASS_BYTE :
		             (top_bits == `FID_CLASS_BITOP) ? `FID_CLASS_BITOP : `FID_CLASS_LIT;
		long_lit   = ((word[`FID_LONG_HI:`FID_LONG_LO] & `FID_LONG_MASK) == `FID_LONG_CODE);
		file_addr  = word[`FID_FILE_HI:`FID_FILE_LO] & `FID_FILE_MAX;
		literal    = 11'h000;
		names_file = 1'b0;
		case (iclass)
			`FID_CLASS_BYTE: begin
				// Misc and clear-accumulator words carry don't-care low bits
				if (is_misc || is_clracc) begin
					file_addr = 7'h00;
				end else begin
					names_file = 1'b1;
				end
				long_lit = 1'b0;
			end
			`FID_CLASS_BITOP: begin
				names_file = 1'b1;
				long_lit   = 1'b0;
			end
			default: begin
				file_addr = 7'h00;
				if (long_lit) begin
					literal = word[`FID_LIT11_HI:0];
				end else begin
					literal = {3'h0, word[`FID_LIT8_HI:0]};
				end
			end
		endcase
	end

endmodule

// ==== hdl/fid_instr_decode.v ====
// Instruction decode and execution timing for a fourteen-bit instruction word.
// Assumes fetch and datapath logic run on mclk; no input crosses a clock domain.
//
// Behaviour
// - Every instruction is one 14-bit word: opcode plus operand fields.
// - Words decode into byte, bit, and literal/control classes.
// - Byte ops write the accumulator when d is 0, the file when 1.
// - Bit ops pick one of eight bits in the addressed file register.
// - File address operand spans locations 0x00 through 0x7F.
// - Literal ops take an 8-bit or 11-bit constant field.
// - One instruction cycle is four consecutive oscillator periods.
// - One cycle each; true test or PC change adds a no-op cycle.
// - File-naming instructions read, modify, then store; read always happens.
// - Read phase of a register clear reaches the port, clearing mismatch.
// - Don't-care bits are ignored; execution same for 0 or 1.
`timescale 1ns/10ps
`include "fid_defs.vh"

module fid_instr_decode (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire [13:0] instr_word,
	input  wire        instr_valid,
	input  wire        cond_true,
	input  wire        pc_changed,
	output wire [1:0]  q_phase,
	output reg         cyc_start,
	output reg         ex_valid,
	output reg  [1:0]  ex_class,
	output reg  [5:0]  ex_opcode,
	output reg         ex_dest_file,
	output reg  [6:0]  ex_file_addr,
	output reg  [2:0]  ex_bit_sel,
	output reg  [10:0] ex_literal,
	output reg         ex_long_lit,
	output reg         rf_read_stb,
	output reg         alu_stb,
	output reg         rf_write_stb,
	output reg         acc_write_stb,
	output reg         dummy_cycle,
	output reg         fetch_flush
);

	// ****************************************
	// Phase generation and field split
	// ****************************************
	wire [1:0]  phase;
	wire        last_phase;
	wire [1:0]  dec_class;
	wire [5:0]  dec_opcode;
	wire        dec_dest;
	wire [6:0]  dec_file;
	wire [2:0]  dec_bit;
	wire [10:0] dec_literal;
	wire        dec_long;
	wire        dec_names_file;

	fid_phase_gen u_phase (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.phase      (phase),
		.last_phase (last_phase)
	);

	fid_field_split u_split (
		.word       (instr_word),
		.iclass     (dec_class),
		.opcode     (dec_opcode),
		.dest_sel   (dec_dest),
		.file_addr  (dec_file),
		.bit_sel    (dec_bit),
		.literal    (dec_literal),
		.long_lit   (dec_long),
		.names_file (dec_names_file)
	);

	assign q_phase = phase;

	// ****************************************
	// Phase decode
	// ****************************************
	wire [3:0] phase_hot;
	genvar     g;

	// One flag per oscillator period of the instruction cycle
	generate
		for (g = 0; g < `FID_PHASES; g = g + 1) begin : g_phase
			assign phase_hot[g] = ({30'h0, phase} == g);
		end
	endgenerate

	// ****************************************
	// Executing instruction state
	// ****************************************
	reg  ex_names_file;
	reg  ex_writes_file;
	reg  ex_writes_acc;
	reg  next_dummy;
	reg  next_writes_file;
	reg  next_writes_acc;
	wire active;
	wire take_word;
	wire drop_word;

	// Dummy cycle blocks every strobe
	assign active = ex_valid && !dummy_cycle;

	// ****************************************
	// Destination decode for the incoming word
	// ****************************************
	// File register store: byte ops with d set, bit set and clear forms
	always @* begin
		next_writes_file = 1'b0;
		case (dec_class)
			`FID_CLASS_BYTE: begin
				if (dec_names_file) begin
					next_writes_file = (dec_dest == `FID_DEST_FILE);
				end
			end
			`FID_CLASS_BITOP: begin
				// Test forms only read
				next_writes_file = !dec_opcode[`FID_BIT_TEST_POS - `FID_OPC_LO];
			end
			default: begin
				next_writes_file = 1'b0;
			end
		endcase
	end

	// Accumulator store: byte ops with d clear, clear-accumulator, short literals
	always @* begin
		next_writes_acc = 1'b0;
		case (dec_class)
			`FID_CLASS_BYTE: begin
				if (dec_names_file) begin
					next_writes_acc = (dec_dest == `FID_DEST_ACC);
				end else begin
					next_writes_acc = (dec_opcode == `FID_OPC_CLRACC);
				end
			end
			`FID_CLASS_BITOP: begin
				next_writes_acc = 1'b0;
			end
			default: begin
				next_writes_acc = !dec_long;
			end
		endcase
	end

	// ****************************************
	// No-op cycle decision
	// ****************************************
	// Second cycle becomes a no-op after a true test or a PC change
	always @* begin
		next_dummy = active && (cond_true || pc_changed);
	end

	// Q4 edge either takes the fetched word or drops it
	assign take_word = last_phase && !next_dummy;
	assign drop_word = last_phase && next_dummy;

	// ****************************************
	// Strobe enables
	// ****************************************
	wire rd_en;
	wire mod_en;
	wire wr_en;
	wire acc_en;

	// Read lands in Q2 even for store-only ops such as a clear
	assign rd_en  = active && ex_names_file && phase_hot[`FID_PH_Q1];
	assign mod_en = active && phase_hot[`FID_PH_Q2];
	assign wr_en  = active && ex_writes_file && phase_hot[`FID_PH_Q3];
	assign acc_en = active && ex_writes_acc && phase_hot[`FID_PH_Q3];

	// ****************************************
	// Instruction cycle boundary
	// ****************************************
	// Q1 marker for the partner logic
	always @(posedge mclk) begin
		if (!rst_n) begin
			cyc_start <= 1'b0;
		end else begin
			cyc_start <= last_phase;
		end
	end

	// No-op cycle level and its one-cycle flush marker
	always @(posedge mclk) begin
		if (!rst_n) begin
			dummy_cycle <= 1'b0;
			fetch_flush <= 1'b0;
		end else begin
			fetch_flush <= drop_word;
			if (last_phase) begin
				dummy_cycle <= next_dummy;
			end
		end
	end

	// ****************************************
	// Class and opcode capture
	// ****************************************
	always @(posedge mclk) begin
		if (!rst_n) begin
			ex_class     <= `FID_CLASS_BYTE;
			ex_opcode    <= 6'h00;
			ex_dest_file <= `FID_DEST_FILE;
		end else if (take_word) begin
			ex_class     <= dec_class;
			ex_opcode    <= dec_opcode;
			ex_dest_file <= dec_dest;
		end
	end

	// ****************************************
	// Operand capture
	// ****************************************
	// Operands hold through a no-op cycle; ex_valid says whether they count
	always @(posedge mclk) begin
		if (!rst_n) begin
			ex_file_addr <= 7'h00;
			ex_bit_sel   <= 3'h0;
			ex_literal   <= 11'h000;
			ex_long_lit  <= 1'b0;
		end else if (take_word) begin
			ex_file_addr <= dec_file;
			ex_bit_sel   <= dec_bit;
			ex_literal   <= dec_literal;
			ex_long_lit  <= dec_long;
		end
	end

	// ****************************************
	// Execution intent
	// ****************************************
	// Prefetched word is discarded during the no-op cycle
	always @(posedge mclk) begin
		if (!rst_n) begin
			ex_valid <= 1'b0;
		end else if (drop_word) begin
			ex_valid <= 1'b0;
		end else if (take_word) begin
			ex_valid <= instr_valid;
		end
	end

	// Idle and dropped words carry no read or store intent
	always @(posedge mclk) begin
		if (!rst_n) begin
			ex_names_file  <= 1'b0;
			ex_writes_file <= 1'b0;
			ex_writes_acc  <= 1'b0;
		end else if (drop_word) begin
			ex_names_file  <= 1'b0;
			ex_writes_file <= 1'b0;
			ex_writes_acc  <= 1'b0;
		end else if (take_word) begin
			ex_names_file  <= instr_valid && dec_names_file;
			ex_writes_file <= instr_valid && next_writes_file;
			ex_writes_acc  <= instr_valid && next_writes_acc;
		end
	end

	// ****************************************
	// Read-modify-write strobes
	// ****************************************
	// Read of the named file register, Q2
	always @(posedge mclk) begin
		if (!rst_n) begin
			rf_read_stb <= 1'b0;
		end else begin
			rf_read_stb <= rd_en;
		end
	end

	// Modify, Q3, for every executing instruction
	always @(posedge mclk) begin
		if (!rst_n) begin
			alu_stb <= 1'b0;
		end else begin
			alu_stb <= mod_en;
		end
	end

	// Store to the file register, Q4
	always @(posedge mclk) begin
		if (!rst_n) begin
			rf_write_stb <= 1'b0;
		end else begin
			rf_write_stb <= wr_en;
		end
	end

	// Store to the accumulator, Q4
	always @(posedge mclk) begin
		if (!rst_n) begin
			acc_write_stb <= 1'b0;
		end else begin
			acc_write_stb <= acc_en;
		end
	end

endmodule

// ==== tb/fid_instr_decode_properties.sv ====
// Concurrent checks on the decode block's ports.
// Assumes binding into fid_instr_decode, one clock, synchronous reset.
`timescale 1ns/10ps
module fid_instr_decode_properties (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       cond_true,
	input wire logic       pc_changed,
	input wire logic [1:0] q_phase,
	input wire logic       cyc_start,
	input wire logic       ex_valid,
	input wire logic [1:0] ex_class,
	input wire logic [5:0] ex_opcode,
	input wire logic       ex_dest_file,
	input wire logic [2:0] ex_bit_sel,
	input wire logic       rf_read_stb,
	input wire logic       alu_stb,
	input wire logic       rf_write_stb,
	input wire logic       acc_write_stb,
	input wire logic       dummy_cycle,
	input wire logic       fetch_flush
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_phase_wrap: assert property (q_phase == 2'h3 |=> cyc_start && q_phase == 2'h0)
		else $error("no cycle start after fourth phase");
	a_alu_third: assert property (alu_stb |-> ex_valid && q_phase == 2'h2)
		else $error("alu strobe off third phase");
	a_read_then_alu: assert property (rf_read_stb |-> ex_valid && q_phase == 2'h1 ##1 alu_stb)
		else $error("file read not in second phase");
	a_write_read: assert property (rf_write_stb |-> $past(rf_read_stb, 2) && q_phase == 2'h3)
		else $error("file write without earlier read");
	a_byte_dest: assert property (ex_class == 2'h0 && (rf_write_stb || acc_write_stb)
		|-> rf_write_stb == ex_dest_file && acc_write_stb != ex_dest_file)
		else $error("byte result to wrong destination");
	a_bit_field: assert property (ex_valid && ex_class == 2'h1
		|-> ex_bit_sel == {ex_opcode[1:0], ex_dest_file})
		else $error("bit select field wrong");
	a_dummy_span: assert property ($rose(dummy_cycle) |-> fetch_flush && !ex_valid
		##1 (dummy_cycle && !fetch_flush && !ex_valid)[*3] ##1 !dummy_cycle)
		else $error("no-op cycle length wrong");
	a_dummy_cause: assert property ($rose(dummy_cycle)
		|-> $past(ex_valid && (cond_true || pc_changed)))
		else $error("no-op cycle without cause");
	a_cause_dummy: assert property (ex_valid && q_phase == 2'h3 && (cond_true || pc_changed)
		|=> dummy_cycle)
		else $error("taken test gave no no-op cycle");
endmodule
bind fid_instr_decode fid_instr_decode_properties fid_props_i (.*);

// ==== tb/fid_datapath_model.sv ====
// Datapath stand-in: reports taken tests and program counter changes.
// Assumes requests are held from Q1 of the executing instruction.
`timescale 1ns/10ps
module fid_datapath_model (
	input  wire logic       mclk,
	input  wire logic       cyc_start,
	input  wire logic       ex_valid,
	input  wire logic [1:0] q_phase,
	input  wire logic       skip_req,
	input  wire logic       jump_req,
	output logic            cond_true,
	output logic            pc_changed
);
	// ****************************************
	// Outcome during Q4 only
	// ****************************************
	logic sk = 1'b0;
	logic jp = 1'b0;
	initial cond_true = 1'b0;
	initial pc_changed = 1'b0;
	always @(negedge mclk) begin
		if (cyc_start) begin
			sk <= skip_req && ex_valid;
			jp <= jump_req && ex_valid;
		end
		cond_true <= q_phase == 2'h3 && sk;
		pc_changed <= q_phase == 2'h3 && jp;
	end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the instruction decode block.
// Assumes the datapath model answers taken tests in Q4.
`timescale 1ns/10ps
module testbench;
	reg         mclk = 1'b0;
	reg         rst_n = 1'b0;
	reg  [13:0] instr_word = 14'h0000;
	reg         instr_valid = 1'b0;
	reg         skip_req = 1'b0;
	reg         jump_req = 1'b0;
	wire        cond_true, pc_changed, cyc_start, ex_valid, ex_dest_file, ex_long_lit;
	wire        rf_read_stb, alu_stb, rf_write_stb, acc_write_stb, dummy_cycle, fetch_flush;
	wire [1:0]  q_phase, ex_class;
	wire [5:0]  ex_opcode;
	wire [6:0]  ex_file_addr;
	wire [2:0]  ex_bit_sel;
	wire [10:0] ex_literal;
	reg  [32:0] q [$];
	reg  [32:0] seen, want;
	reg  [31:0] r;
	reg         drop = 1'b0;
	integer     seed = 21;
	integer     fail_count = 0;
	integer     n_checks = 0;
	reg  [13:0] dir [0:7] = '{14'h07ff, 14'h0780, 14'h017f, 14'h1bff,
		14'h0100, 14'h17ff, 14'h2fff, 14'h3fff};

	fid_instr_decode fid_instr_decode_i (.*);
	fid_datapath_model fid_datapath_model_i (.mclk(mclk), .cyc_start(cyc_start),
		.ex_valid(ex_valid), .q_phase(q_phase), .skip_req(skip_req),
		.jump_req(jump_req), .cond_true(cond_true), .pc_changed(pc_changed));

	always #25 mclk = ~mclk;

	// ****************************************
	// Expectation and checking
	// ****************************************
	function [32:0] exp_of(input [13:0] w);
		reg [1:0] c;
		reg [6:0] f;
		reg [10:0] l;
		reg lg, wf, wa;
		begin
			c = w[13] ? 2'h2 : {1'b0, w[12]};
			lg = w[13] && !w[12];
			f = (c == 2'h2 || (w[13:9] == 5'h00 && !w[7])) ? 7'h00 : w[6:0];
			l = (c != 2'h2) ? 11'h000 : lg ? w[10:0] : {3'h0, w[7:0]};
			wf = (c == 2'h0) ? w[7] : (c == 2'h1 && !w[11]);
			wa = (c == 2'h0 && !w[7] && w[13:8] != 6'h00) || (c == 2'h2 && !lg);
			exp_of = {c, w[13:8], w[7], f, w[9:7], l, lg, wf, wa};
		end
	endfunction

	task check(input [32:0] got, input [32:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, got, exp);
			end
		end
	endtask

	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, fail_count);
			if (fail_count == 0 && n_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task step(input [13:0] w, input v, input sk, input jp);
		integer k;
		begin
			k = 0;
			@(negedge mclk);
			while (q_phase !== 2'h3 && k < 8) begin
				@(negedge mclk);
				k = k + 1;
			end
			if (k == 8) begin
				fail_count = fail_count + 1;
				close_out;
			end else begin
				instr_word = w;
				instr_valid = v;
				skip_req = sk;
				jump_req = jp;
				if (v && !drop)
					q.push_back(exp_of(w));
				drop = v && !drop && (sk || jp);
			end
		end
	endtask

	always @(negedge mclk) begin
		if (rst_n && ex_valid === 1'b1 && q_phase === 2'h3) begin
			seen = {ex_class, ex_opcode, ex_dest_file, ex_file_addr, ex_bit_sel,
				ex_literal, ex_long_lit, rf_write_stb, acc_write_stb};
			want = (q.size() > 0) ? q.pop_front() : ~seen;
			check(seen, want);
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		foreach (dir[i])
			step(dir[i], 1'b1, i == 3, i == 5);
		step(14'h3fff, 1'b0, 1'b0, 1'b0);
		$display("test done: directed");
		repeat (300) begin
			r = $random(seed);
			step(r[13:0], r[16:14] != 3'h0, r[19:17] == 3'h0, r[23:20] == 4'h0);
		end
		step(14'h0000, 1'b0, 1'b0, 1'b0);
		$display("test done: random");
		repeat (12) @(negedge mclk);
		check(33'(q.size()), 33'h0);
		close_out;
	end
endmodule
